// ---- verification/oag_biu_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bus interface model with a chosen latency.
// ----------------------------------------
module oag_biu_model #(
	parameter logic [15:0] SEG_BASE = 16'h1000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic memReq,
	input wire oag_pkg::oag_memreq_t memAddr,
	input wire logic [1:0] latency,
	output logic biuDone
);
	logic [1:0] cnt_q;
	logic done_q;
	logic [19:0] physAddr;
	assign physAddr = {SEG_BASE, 4'h0} + {4'h0, memAddr.ea};
	assign biuDone = done_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 2'h0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!memReq || done_q) begin
				cnt_q <= 2'h0;
			end else if (cnt_q == latency) begin
				done_q <= 1'b1;
				cnt_q <= 2'h0;
			end else begin
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end
endmodule

// ---- verification/oag_operand_address_generator_asserts.sv ----
`timescale 1ns/1ps
`include "oag_params.svh"
// ----------------------------------------
// Checker of the address generator.
// ----------------------------------------
module oag_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic instrValid,
	input wire oag_pkg::oag_instr_t instr,
	input wire logic intPending,
	input wire logic coprocTestN,
	input wire logic biuDone,
	input wire logic instrReady_q,
	input wire oag_pkg::oag_flags_t flags_q,
	input wire logic halted_q,
	input wire logic testWaiting_q,
	input wire logic memReq_q,
	input wire oag_pkg::oag_memreq_t memAddr_q,
	input wire logic illegalOp_q
);
	wire acc = instrValid && instrReady_q;
	wire ill = instr.dstIsImm && instr.hasImm;
	wire regOnly = instr.hasModrm && instr.modrm[7:6] == `OAG_MOD_REGISTER;
	wire flagOp = instr.opcode inside {`OAG_OP_CARRY_SET, `OAG_OP_CARRY_CLEAR,
		`OAG_OP_CARRY_INVERT, `OAG_OP_DIRECTION_SET, `OAG_OP_DIRECTION_CLEAR,
		`OAG_OP_INT_ENABLE_SET, `OAG_OP_INT_ENABLE_CLEAR};
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_flags_keep: assert property (acc && !flagOp |=> $stable(flags_q))
		else $error("flags moved on another instruction");
	a_carry_set: assert property (acc && !ill && instr.opcode == `OAG_OP_CARRY_SET
		|=> flags_q.carry)
		else $error("carry not set");
	a_carry_flip: assert property (acc && !ill &&
		instr.opcode == `OAG_OP_CARRY_INVERT |=> flags_q.carry != $past(flags_q.carry))
		else $error("carry not inverted");
	a_halt_held: assert property (halted_q && !intPending |=> halted_q && !instrReady_q)
		else $error("halt left without interrupt");
	a_halt_leave: assert property (halted_q && intPending |=> !halted_q && instrReady_q)
		else $error("halt not left on interrupt");
	a_test_stall: assert property (testWaiting_q && $past(coprocTestN, 2)
		|=> testWaiting_q)
		else $error("wait left with test pin inactive");
	a_reg_nobus: assert property (acc && regOnly |=> !memReq_q)
		else $error("bus cycle for register operand");
	a_imm_refuse: assert property (acc && ill |=> illegalOp_q && !memReq_q)
		else $error("immediate destination not refused");
	a_addr_hold: assert property (memReq_q && !biuDone |=> memReq_q && $stable(memAddr_q))
		else $error("memory offset dropped early");
	c_mem_done: cover property (memReq_q && biuDone);
	c_halt_exit: cover property (halted_q && intPending);
	c_refused: cover property (acc && ill);
endmodule

bind oag_operand_address_generator oag_checker i_chk (.sys_clk, .rst, .instrValid, .instr,
	.intPending, .coprocTestN, .biuDone, .instrReady_q, .flags_q, .halted_q,
	.testWaiting_q, .memReq_q, .memAddr_q, .illegalOp_q);

// ---- verification/oag_operand_address_generator_bench.sv ----
`timescale 1ns/1ps
`include "oag_params.svh"
module oag_operand_address_generator_bench;
	logic sys_clk, rst, instrValid, intPending, coprocTestN, biuDone, instrReady_q;
	logic halted_q, testWaiting_q, memReq_q, busLock_q, immValid_q, coprocStart_q;
	logic jumpValid_q, illegalOp_q;
	logic [1:0] latency;
	logic [15:0] immData_q, jumpTarget_q;
	oag_pkg::oag_instr_t instr, t;
	oag_pkg::oag_regs_t regs;
	oag_pkg::oag_flags_t flags_q;
	oag_pkg::oag_memreq_t memAddr_q;
	oag_pkg::oag_escape_t coprocOp_q;
	int miscompares, checked, c, d, ie, ea, sg, k;
	logic [7:0] ops [7] = '{`OAG_OP_CARRY_SET, `OAG_OP_CARRY_CLEAR, `OAG_OP_CARRY_INVERT,
		`OAG_OP_DIRECTION_SET, `OAG_OP_DIRECTION_CLEAR, `OAG_OP_INT_ENABLE_SET,
		`OAG_OP_INT_ENABLE_CLEAR};
	oag_operand_address_generator i_dut (.sys_clk, .rst, .instrValid, .instr, .regs,
		.intPending, .coprocTestN, .biuDone, .instrReady_q, .flags_q, .halted_q,
		.testWaiting_q, .memReq_q, .memAddr_q, .busLock_q, .immValid_q, .immData_q,
		.coprocStart_q, .coprocOp_q, .jumpValid_q, .jumpTarget_q, .illegalOp_q);
	oag_biu_model i_biu (.sys_clk, .rst, .memReq(memReq_q), .memAddr(memAddr_q),
		.latency, .biuDone);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task send;
		int n;
		n = 0;
		@(posedge sys_clk);
		#1;
		while (instrReady_q !== 1'b1) begin
			n++;
			if (n > 60) begin
				miscompares++;
				conclude;
			end
			@(posedge sys_clk);
			#1;
		end
		instr = t;
		instrValid = 1'b1;
		@(posedge sys_clk);
		#1;
		instrValid = 1'b0;
	endtask
	task mem_op;
		int b, m, r;
		t = '0;
		t.opcode = 8'h8b;
		t.hasModrm = 1'b1;
		t.modrm = $urandom;
		t.modrm[7:6] = $urandom % 3;
		t.disp = $urandom;
		t.segOvrValid = $urandom;
		t.segOvr = $urandom;
		regs = {$urandom, $urandom, $urandom, $urandom};
		latency = $urandom;
		m = t.modrm[7:6];
		r = t.modrm[2:0];
		case (r)
			0: b = regs.bx + regs.si;
			1: b = regs.bx + regs.di;
			2: b = regs.bp + regs.si;
			3: b = regs.bp + regs.di;
			4: b = regs.si;
			5: b = regs.di;
			6: b = (m == 0) ? 0 : regs.bp;
			default: b = regs.bx;
		endcase
		ea = b + ((m == 1) ? int'($signed(t.disp[7:0])) :
			(m == 2 || (m == 0 && r == 6)) ? int'(t.disp) : 0);
		sg = t.segOvrValid ? t.segOvr : (r == 2 || r == 3 || (r == 6 && m != 0)) ?
			`OAG_SEG_STACK : `OAG_SEG_DATA;
		send;
		chk(memReq_q, 1);
		chk(memAddr_q, {ea[15:0], sg[1:0]});
		chk(i_biu.physAddr, 32'h10000 + ea[15:0]);
	endtask
	initial begin
		rst = 1'b1;
		instrValid = 1'b0;
		instr = '0;
		t = '0;
		regs = '0;
		intPending = 1'b0;
		coprocTestN = 1'b1;
		latency = 2'h0;
		{miscompares, checked, c, d, ie} = '0;
		k = $urandom(32'h380f);
		repeat (16) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		repeat (24) begin
			t = '0;
			t.opcode = ops[$urandom % 7];
			case (t.opcode)
				`OAG_OP_CARRY_SET: c = 1;
				`OAG_OP_CARRY_CLEAR: c = 0;
				`OAG_OP_CARRY_INVERT: c = 1 - c;
				`OAG_OP_DIRECTION_SET: d = 1;
				`OAG_OP_DIRECTION_CLEAR: d = 0;
				`OAG_OP_INT_ENABLE_SET: ie = 1;
				default: ie = 0;
			endcase
			send;
			chk(flags_q, {c[0], d[0], ie[0]});
		end
		repeat (60) mem_op;
		t = '0;
		t.opcode = `OAG_OP_LOCK;
		send;
		mem_op;
		chk(busLock_q, 1);
		repeat (8) begin
			regs = {$urandom, $urandom, $urandom, $urandom};
			k = $urandom % 8;
			t = '0;
			t.opcode = `OAG_OP_GROUP_FF;
			t.hasModrm = 1'b1;
			t.modrm = {`OAG_MOD_REGISTER, ($urandom % 2) ? `OAG_SUB_CALL : `OAG_SUB_JUMP, k[2:0]};
			send;
			chk(jumpValid_q, 1);
			chk(busLock_q, 0);
			chk(jumpTarget_q, regs[(7 - k) * 16 +: 16]);
			chk(memReq_q, 0);
			t = '0;
			t.opcode = 8'h81;
			t.hasModrm = 1'b1;
			t.modrm = 8'hc0 | k[7:0];
			t.hasImm = 1'b1;
			t.immWide = k[1];
			t.imm = $urandom;
			send;
			chk(immValid_q, 1);
			chk(immData_q, t.immWide ? t.imm : {{8{t.imm[7]}}, t.imm[7:0]});
			chk(memReq_q, 0);
			t.dstIsImm = 1'b1;
			send;
			chk(illegalOp_q, 1);
			t = '0;
			t.opcode = 8'hd8 | k[7:0];
			t.hasModrm = 1'b1;
			t.modrm = 8'hc0 | $urandom;
			send;
			chk(coprocStart_q, 1);
			chk(coprocOp_q, {t.opcode, t.modrm});
		end
		t = '0;
		t.opcode = `OAG_OP_HALT;
		send;
		repeat (5) @(posedge sys_clk);
		#1;
		chk(halted_q, 1);
		intPending = 1'b1;
		@(posedge sys_clk);
		#1;
		intPending = 1'b0;
		chk({halted_q, instrReady_q}, 2'b01);
		t.opcode = `OAG_OP_TEST_WAIT;
		send;
		repeat (4) @(posedge sys_clk);
		#1;
		chk(testWaiting_q, 1);
		coprocTestN = 1'b0;
		k = 0;
		while (testWaiting_q === 1'b1 && k < 8) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		chk(testWaiting_q, 0);
		coprocTestN = 1'b1;
		chk(flags_q, {c[0], d[0], ie[0]});
		conclude;
	end
endmodule

// ---- verilog/oag_operand_address_generator.sv ----
`timescale 1ns/1ps
`include "oag_params.svh"

// Behaviour
// - Control instructions other than flag operations leave all flags unchanged.
// - Own opcodes set, clear or invert carry; set/clear direction and interrupt enable.
// - Halt stops execution until an interrupt or a reset.
// - Wait stalls execution until the coprocessor test pin is active.
// - Escape hands its operation to the external processor, not executed here.
// - Lock prefix keeps the bus locked during the following instruction.
// - Register-only instructions run internally and request no bus cycle.
// - Immediates of 8 or 16 bits come from the queue without bus cycles.
// - An immediate may only be a source, never a destination.
// - Memory operands pass an offset and segment to the bus interface unit.
// - Effective address is an unsigned 16-bit byte offset into the segment.
// - Effective address computation is chosen by second-byte fields.
// - Effective address sums displacement, base and index, in any combination.
// - Displacement is an 8 or 16-bit constant from the instruction.
// - Base component is only the general base or frame base register.
// - Index component is only the source or destination index register.
// - Frame base addressing uses stack segment unless a segment override is given.
// - Direct mode effective address equals the displacement alone.
// - Register indirect mode uses the base or index register without displacement.
// - Register indirect jump or call accepts any 16-bit general register.
// - Based mode adds displacement to general base or frame base register.
module oag_operand_address_generator (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic instrValid,
	input wire oag_pkg::oag_instr_t instr,
	input wire oag_pkg::oag_regs_t regs,
	input wire logic intPending,
	input wire logic coprocTestN,
	input wire logic biuDone,
	output logic instrReady_q,
	output oag_pkg::oag_flags_t flags_q,
	output logic halted_q,
	output logic testWaiting_q,
	output logic memReq_q,
	output oag_pkg::oag_memreq_t memAddr_q,
	output logic busLock_q,
	output logic immValid_q,
	output logic [15:0] immData_q,
	output logic coprocStart_q,
	output oag_pkg::oag_escape_t coprocOp_q,
	output logic jumpValid_q,
	output logic [15:0] jumpTarget_q,
	output logic illegalOp_q
);

	// -----------------------------------------------------------
	// Address functions
	// -----------------------------------------------------------
	function automatic logic [15:0] signExt8(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction

	function automatic logic [15:0] regByCode(input logic [2:0] code,
		input oag_pkg::oag_regs_t r);
		logic [15:0] v;
		v = r.ax;
		unique case (code)
			3'h0: v = r.ax;
			3'h1: v = r.cx;
			3'h2: v = r.dx;
			3'h3: v = r.bx;
			3'h4: v = r.sp;
			3'h5: v = r.bp;
			3'h6: v = r.si;
			3'h7: v = r.di;
		endcase
		return v;
	endfunction

	function automatic logic isDirect(input logic [7:0] m);
		return m[`OAG_MOD_HI:`OAG_MOD_LO] == `OAG_MOD_NODISP &&
			m[`OAG_RM_HI:`OAG_RM_LO] == `OAG_RM_DIRECT;
	endfunction

	function automatic logic usesFrameBase(input logic [7:0] m);
		logic [2:0] rm;
		rm = m[`OAG_RM_HI:`OAG_RM_LO];
		return rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && !isDirect(m));
	endfunction

	function automatic logic [15:0] dispOf(input logic [7:0] m, input logic [15:0] d);
		logic [15:0] v;
		v = 16'h0000;
		unique case (m[`OAG_MOD_HI:`OAG_MOD_LO])
			`OAG_MOD_DISP8: v = signExt8(d[7:0]);
			`OAG_MOD_DISP16: v = d;
			`OAG_MOD_NODISP: v = isDirect(m) ? d : 16'h0000;
			`OAG_MOD_REGISTER: v = 16'h0000;
		endcase
		return v;
	endfunction

	function automatic logic [15:0] baseOf(input logic [7:0] m,
		input oag_pkg::oag_regs_t r);
		logic [15:0] v;
		v = 16'h0000;
		unique case (m[`OAG_RM_HI:`OAG_RM_LO])
			3'h0, 3'h1, 3'h7: v = r.bx;
			3'h2, 3'h3: v = r.bp;
			3'h6: v = isDirect(m) ? 16'h0000 : r.bp;
			3'h4, 3'h5: v = 16'h0000;
		endcase
		return v;
	endfunction

	function automatic logic [15:0] indexOf(input logic [7:0] m,
		input oag_pkg::oag_regs_t r);
		logic [15:0] v;
		v = 16'h0000;
		unique case (m[`OAG_RM_HI:`OAG_RM_LO])
			3'h0, 3'h2, 3'h4: v = r.si;
			3'h1, 3'h3, 3'h5: v = r.di;
			3'h6, 3'h7: v = 16'h0000;
		endcase
		return v;
	endfunction

	function automatic logic [15:0] effAddr(input logic [7:0] m, input logic [15:0] d,
		input oag_pkg::oag_regs_t r);
		logic [17:0] s;
		s = {2'h0, dispOf(m, d)} + {2'h0, baseOf(m, r)} + {2'h0, indexOf(m, r)};
		return s[15:0];
	endfunction

	// -----------------------------------------------------------
	// Test pin synchroniser
	// -----------------------------------------------------------
	logic testMeta_q;
	logic testSync_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			testMeta_q <= 1'b1;
			testSync_q <= 1'b1;
		end else begin
			testMeta_q <= coprocTestN;
			testSync_q <= testMeta_q;
		end
	end

	// -----------------------------------------------------------
	// Decode of the accepted instruction
	// -----------------------------------------------------------
	oag_pkg::oag_state_t state_q;
	oag_pkg::oag_state_t state_d;
	logic lockPending_q;
	logic accept;
	logic illegal;
	logic isEscape;
	logic isRegOnly;
	logic isMem;
	logic isRegJump;
	logic [2:0] subOp;

	assign accept = instrValid && instrReady_q;
	assign illegal = instr.hasImm && instr.dstIsImm;
	assign isEscape = instr.opcode[7:3] == `OAG_ESC_PREFIX;
	assign isRegOnly = instr.hasModrm &&
		instr.modrm[`OAG_MOD_HI:`OAG_MOD_LO] == `OAG_MOD_REGISTER;
	assign isMem = instr.hasModrm && !isRegOnly;
	assign subOp = instr.modrm[`OAG_REG_HI:`OAG_REG_LO];
	assign isRegJump = instr.opcode == `OAG_OP_GROUP_FF && isRegOnly &&
		(subOp == `OAG_SUB_CALL || subOp == `OAG_SUB_JUMP);

	// -----------------------------------------------------------
	// Execution state
	// -----------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			oag_pkg::OAG_RUN: begin
				if (accept && !illegal) begin
					if (instr.opcode == `OAG_OP_HALT) begin
						state_d = oag_pkg::OAG_HALTED;
					end else if (instr.opcode == `OAG_OP_TEST_WAIT) begin
						state_d = oag_pkg::OAG_TESTWAIT;
					end else if (isMem) begin
						state_d = oag_pkg::OAG_MEMWAIT;
					end
				end
			end
			oag_pkg::OAG_MEMWAIT: begin
				if (biuDone) begin
					state_d = oag_pkg::OAG_RUN;
				end
			end
			oag_pkg::OAG_TESTWAIT: begin
				if (!testSync_q) begin
					state_d = oag_pkg::OAG_RUN;
				end
			end
			oag_pkg::OAG_HALTED: begin
				if (intPending) begin
					state_d = oag_pkg::OAG_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= oag_pkg::OAG_RUN;
			instrReady_q <= 1'b1;
			halted_q <= 1'b0;
			testWaiting_q <= 1'b0;
			memReq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			instrReady_q <= state_d == oag_pkg::OAG_RUN;
			halted_q <= state_d == oag_pkg::OAG_HALTED;
			testWaiting_q <= state_d == oag_pkg::OAG_TESTWAIT;
			memReq_q <= state_d == oag_pkg::OAG_MEMWAIT;
		end
	end

	// -----------------------------------------------------------
	// Flags
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags_q.carry <= `OAG_RST_CARRY;
			flags_q.direction <= `OAG_RST_DIRECTION;
			flags_q.intEnable <= `OAG_RST_INT_ENABLE;
		end else if (accept && !illegal) begin
			unique case (instr.opcode)
				`OAG_OP_CARRY_SET: flags_q.carry <= 1'b1;
				`OAG_OP_CARRY_CLEAR: flags_q.carry <= 1'b0;
				`OAG_OP_CARRY_INVERT: flags_q.carry <= !flags_q.carry;
				`OAG_OP_DIRECTION_SET: flags_q.direction <= 1'b1;
				`OAG_OP_DIRECTION_CLEAR: flags_q.direction <= 1'b0;
				`OAG_OP_INT_ENABLE_SET: flags_q.intEnable <= 1'b1;
				`OAG_OP_INT_ENABLE_CLEAR: flags_q.intEnable <= 1'b0;
				default: flags_q <= flags_q;
			endcase
		end
	end

	// -----------------------------------------------------------
	// Memory operand address and segment
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			memAddr_q <= '0;
		end else if (accept && !illegal && isMem) begin
			memAddr_q.ea <= effAddr(instr.modrm, instr.disp, regs);
			if (instr.segOvrValid) begin
				memAddr_q.seg <= instr.segOvr;
			end else if (usesFrameBase(instr.modrm)) begin
				memAddr_q.seg <= `OAG_SEG_STACK;
			end else begin
				memAddr_q.seg <= `OAG_SEG_DATA;
			end
		end
	end

	// -----------------------------------------------------------
	// Bus lock
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lockPending_q <= 1'b0;
		end else if (accept) begin
			lockPending_q <= instr.opcode == `OAG_OP_LOCK;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busLock_q <= 1'b0;
		end else if (accept) begin
			busLock_q <= lockPending_q;
		end else if (state_q == oag_pkg::OAG_RUN) begin
			busLock_q <= 1'b0;
		end
	end

	// -----------------------------------------------------------
	// Immediate operands
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			immValid_q <= 1'b0;
			immData_q <= 16'h0000;
		end else begin
			immValid_q <= accept && !illegal && instr.hasImm;
			if (accept && instr.hasImm) begin
				immData_q <= instr.immWide ? instr.imm : signExt8(instr.imm[7:0]);
			end
		end
	end

	// -----------------------------------------------------------
	// Escape hand-off
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			coprocStart_q <= 1'b0;
			coprocOp_q <= '0;
		end else begin
			coprocStart_q <= accept && !illegal && isEscape;
			if (accept && isEscape) begin
				coprocOp_q.opcode <= instr.opcode;
				coprocOp_q.modrm <= instr.modrm;
			end
		end
	end

	// -----------------------------------------------------------
	// Register indirect jump and call target
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			jumpValid_q <= 1'b0;
			jumpTarget_q <= 16'h0000;
		end else begin
			jumpValid_q <= accept && !illegal && isRegJump;
			if (accept && isRegJump) begin
				jumpTarget_q <= regByCode(instr.modrm[`OAG_RM_HI:`OAG_RM_LO], regs);
			end
		end
	end

	// -----------------------------------------------------------
	// Illegal operand form
	// -----------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			illegalOp_q <= 1'b0;
		end else begin
			illegalOp_q <= accept && illegal;
		end
	end

endmodule

// ---- verilog/oag_params.svh ----
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH

// ---------------------------------------------------------------
// Opcodes of the processor-control group and of the FF group
// ---------------------------------------------------------------
`define OAG_OP_CARRY_SET 8'hf9
`define OAG_OP_CARRY_CLEAR 8'hf8
`define OAG_OP_CARRY_INVERT 8'hf5
`define OAG_OP_DIRECTION_SET 8'hfd
`define OAG_OP_DIRECTION_CLEAR 8'hfc
`define OAG_OP_INT_ENABLE_SET 8'hfb
`define OAG_OP_INT_ENABLE_CLEAR 8'hfa
`define OAG_OP_HALT 8'hf4
`define OAG_OP_TEST_WAIT 8'h9b
`define OAG_OP_LOCK 8'hf0
`define OAG_OP_NOP 8'h90
`define OAG_OP_GROUP_FF 8'hff
`define OAG_ESC_PREFIX 5'h1b

// ---------------------------------------------------------------
// Second-byte field positions and codes
// ---------------------------------------------------------------
`define OAG_MOD_HI 7
`define OAG_MOD_LO 6
`define OAG_REG_HI 5
`define OAG_REG_LO 3
`define OAG_RM_HI 2
`define OAG_RM_LO 0
`define OAG_MOD_NODISP 2'h0
`define OAG_MOD_DISP8 2'h1
`define OAG_MOD_DISP16 2'h2
`define OAG_MOD_REGISTER 2'h3
`define OAG_RM_DIRECT 3'h6
`define OAG_SUB_CALL 3'h2
`define OAG_SUB_JUMP 3'h4

// ---------------------------------------------------------------
// Segment select codes
// ---------------------------------------------------------------
`define OAG_SEG_EXTRA 2'h0
`define OAG_SEG_CODE 2'h1
`define OAG_SEG_STACK 2'h2
`define OAG_SEG_DATA 2'h3

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define OAG_RST_CARRY 1'b0
`define OAG_RST_DIRECTION 1'b0
`define OAG_RST_INT_ENABLE 1'b0

`endif

// ---- verilog/oag_pkg.sv ----
package oag_pkg;

	// -----------------------------------------------------------
	// Execution states
	// -----------------------------------------------------------
	typedef enum logic [1:0] {
		OAG_RUN = 2'h0,
		OAG_MEMWAIT = 2'h1,
		OAG_TESTWAIT = 2'h3,
		OAG_HALTED = 2'h2
	} oag_state_t;

	// -----------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] modrm;
		logic [15:0] disp;
		logic [15:0] imm;
		logic hasModrm;
		logic hasImm;
		logic immWide;
		logic dstIsImm;
		logic segOvrValid;
		logic [1:0] segOvr;
	} oag_instr_t;

	typedef struct packed {
		logic [15:0] ax;
		logic [15:0] cx;
		logic [15:0] dx;
		logic [15:0] bx;
		logic [15:0] sp;
		logic [15:0] bp;
		logic [15:0] si;
		logic [15:0] di;
	} oag_regs_t;

	typedef struct packed {
		logic carry;
		logic direction;
		logic intEnable;
	} oag_flags_t;

	typedef struct packed {
		logic [15:0] ea;
		logic [1:0] seg;
	} oag_memreq_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] modrm;
	} oag_escape_t;

endpackage
